//--- src/dbg_pkg.sv
`default_nettype none
package dbg_pkg;
  // register map, byte addresses
  localparam logic [31:0] DBG_IDENT_ADDR = 32'hE004_2000;
  localparam logic [31:0] DBG_CTRL_OFS = 32'h0000_0004;
  localparam logic [31:0] DBG_CTRL_ADDR = DBG_IDENT_ADDR + DBG_CTRL_OFS;
  // control register reset and writable bits
  localparam logic [31:0] DBG_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] DBG_CTRL_WMASK = 32'h0000_3F27;
  // control field positions
  localparam int DBG_B_SLEEP = 0;
  localparam int DBG_B_DEEP = 1;
  localparam int DBG_B_STBY = 2;
  localparam int DBG_B_TRACE = 5;
  localparam int DBG_B_HOLD_LO = 8;   // independent watchdog
  localparam int DBG_B_HOLD_HI = 13;  // timer 4
  localparam int DBG_HOLD_N = 6;
  // link switching sequences, sent lsb first
  localparam logic [15:0] DBG_SEQ_TO_SWD = 16'hE79E;
  localparam logic [15:0] DBG_SEQ_TO_JTAG = 16'hE73C;
  localparam logic [4:0] DBG_SEQ_LEN = 5'h10;
  localparam logic [5:0] DBG_SEQ_MIN_HIGH = 6'h32;
  // switch sequence detector states
  typedef enum logic [2:0] {
    DBG_SQ_LEAD = 3'b001,
    DBG_SQ_PAT = 3'b010,
    DBG_SQ_TAIL = 3'b100
  } dbg_seq_state_t;
endpackage
`default_nettype wire

//--- src/dbg_sync2.sv
`default_nettype none
// two flip-flop level synchroniser, one per bit
module dbg_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;  // first stage, read only by q
  // plain double register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

//--- src/dbg_hold_gate.sv
`default_nettype none
// registered per-unit freeze requests
module dbg_hold_gate #(
  parameter int N = 6
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic halted,
  input wire logic [N-1:0] sel,
  output logic [N-1:0] hold_q
);
  genvar i;
  // one flop per unit; drops the cycle after resume
  for (i = 0; i < N; i++) begin : g_hold
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        hold_q[i] <= 1'b0;
      end else begin
        hold_q[i] <= halted & sel[i];
      end
    end
  end
endmodule
`default_nettype wire

//--- src/dbg_port_hold.sv
`default_nettype none
// debug support unit: link protocol switch, freeze and clock-keep control
module dbg_port_hold
  import dbg_pkg::*;
#(
  // arbitrary identity value, not a real part code
  parameter logic [31:0] IDENT_VALUE = 32'h1234_5678
) (
  // system clock domain
  input wire logic clk,
  // power-on reset, active low
  input wire logic rstn,
  // register port
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata_q,
  // core and power state
  input wire logic core_halted,
  input wire logic sleep_mode,
  input wire logic deepsleep_mode,
  input wire logic standby_mode,
  // port mode config: pin moved to gpio
  input wire logic swclk_gpio_sel,
  input wire logic swdio_gpio_sel,
  input wire logic trace_gpio_sel,
  // debug link, on the probe clock
  input wire logic swclk,
  input wire logic swdio_in,
  output logic swdio_out_q,
  output logic swdio_oe_n_q,
  // protocol state seen in clk domain
  output logic swd_active_q,
  output logic jtag_active_q,
  output logic debug_session_q,
  // freeze requests
  output logic [3:0] tim_hold_q,
  output logic win_dog_hold_q,
  output logic ind_dog_hold_q,
  // clock and power controller requests
  output logic sleep_clk_keep_q,
  output logic fast_clk_keep_q,
  output logic standby_reset_req_q,
  // pin ownership
  output logic swclk_pin_dbg_q,
  output logic swdio_pin_dbg_q,
  output logic trace_pin_dbg_q
);

  ////////////////////////////////////////////////////////////////////////
  // link side: switching sequence detector on swclk
  ////////////////////////////////////////////////////////////////////////

  // link data after two swclk flops
  logic tms_s;
  // detector state
  dbg_seq_state_t sq_q;
  dbg_seq_state_t sq_d;
  // run of high cycles, saturating
  logic [5:0] high_q;
  logic [5:0] high_d;
  // pattern bits gathered so far
  logic [4:0] nbit_q;
  logic [4:0] nbit_d;
  // pattern shift register, lsb arrives first
  logic [15:0] pat_q;
  logic [15:0] pat_d;
  // selected protocol: 1 = swd, 0 = jtag
  logic link_swd_q;
  logic link_swd_d;
  // next pattern word including the new bit
  logic [15:0] pat_next;
  // pattern matching the current protocol's exit
  logic pat_hit;

  // the pin is sampled on the probe's own clock;
  // two flops keep metastability off the detector
  dbg_sync2 #(
    .W(1)
  ) u_tms_sync (
    .clk(swclk),
    .rstn(rstn),
    .d(swdio_in),
    .q(tms_s)
  );

  // the word after shifting in this cycle's bit
  assign pat_next = {tms_s, pat_q[15:1]};

  // only the sequence leaving the current protocol counts
  always_comb begin
    if (link_swd_q) begin
      pat_hit = (pat_next == DBG_SEQ_TO_JTAG);
    end else begin
      pat_hit = (pat_next == DBG_SEQ_TO_SWD);
    end
  end

  // detector next state
  always_comb begin
    sq_d = sq_q;
    high_d = high_q;
    nbit_d = nbit_q;
    pat_d = pat_q;
    link_swd_d = link_swd_q;
    case (sq_q)
      // count the leading run of high cycles
      DBG_SQ_LEAD: begin
        if (tms_s) begin
          if (high_q != DBG_SEQ_MIN_HIGH) begin
            high_d = high_q + 6'h01;
          end
        end else if (high_q == DBG_SEQ_MIN_HIGH) begin
          // both patterns open with a low bit
          sq_d = DBG_SQ_PAT;
          pat_d = pat_next;
          nbit_d = 5'h01;
          high_d = 6'h00;
        end else begin
          high_d = 6'h00;
        end
      end
      // gather sixteen pattern bits
      DBG_SQ_PAT: begin
        pat_d = pat_next;
        nbit_d = nbit_q + 5'h01;
        if (nbit_q == DBG_SEQ_LEN - 5'h01) begin
          high_d = 6'h00;
          if (pat_hit) begin
            sq_d = DBG_SQ_TAIL;
          end else begin
            // a wrong word restarts the hunt
            sq_d = DBG_SQ_LEAD;
          end
        end
      end
      // trailing run of high cycles
      DBG_SQ_TAIL: begin
        if (!tms_s) begin
          sq_d = DBG_SQ_LEAD;
          high_d = 6'h00;
        end else if (high_q == DBG_SEQ_MIN_HIGH - 6'h01) begin
          // fiftieth high cycle: switch protocol
          link_swd_d = !link_swd_q;
          sq_d = DBG_SQ_LEAD;
          high_d = 6'h00;
        end else begin
          high_d = high_q + 6'h01;
        end
      end
      default: begin
        sq_d = DBG_SQ_LEAD;
        high_d = 6'h00;
      end
    endcase
  end

  // detector registers; the sync flops put each bit two swclk
  // edges late, so a switch needs two edges after the last high bit
  always_ff @(posedge swclk or negedge rstn) begin
    if (!rstn) begin
      sq_q <= DBG_SQ_LEAD;
      high_q <= 6'h00;
      nbit_q <= 5'h00;
      pat_q <= 16'h0000;
    end else begin
      sq_q <= sq_d;
      high_q <= high_d;
      nbit_q <= nbit_d;
      pat_q <= pat_d;
    end
  end

  // protocol select, jtag out of reset
  always_ff @(posedge swclk or negedge rstn) begin
    if (!rstn) begin
      link_swd_q <= 1'b0;
    end else begin
      link_swd_q <= link_swd_d;
    end
  end

  // this unit never answers on the data line itself;
  // the core's access port owns the response path
  always_ff @(posedge swclk or negedge rstn) begin
    if (!rstn) begin
      swdio_out_q <= 1'b0;
      swdio_oe_n_q <= 1'b1;
    end else begin
      swdio_out_q <= 1'b0;
      swdio_oe_n_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // crossing into the system clock
  ////////////////////////////////////////////////////////////////////////

  // protocol level seen in clk domain
  logic swd_s;

  // a level, so two flops suffice
  dbg_sync2 #(
    .W(1)
  ) u_mode_sync (
    .clk(clk),
    .rstn(rstn),
    .d(link_swd_q),
    .q(swd_s)
  );

  // protocol flags for the rest of the chip
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      swd_active_q <= 1'b0;
      jtag_active_q <= 1'b1;
    end else begin
      swd_active_q <= swd_s;
      jtag_active_q <= !swd_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register port
  ////////////////////////////////////////////////////////////////////////

  // control word, cleared only by power-on reset
  logic [31:0] ctrl_q;
  // address decode
  logic sel_id;
  logic sel_ctrl;

  assign sel_id = (addr == DBG_IDENT_ADDR);
  assign sel_ctrl = (addr == DBG_CTRL_ADDR);

  // control writes; reserved bits are masked off so
  // they stay at their reset value whatever is written
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= DBG_CTRL_RST;
    end else if (wr_en && sel_ctrl) begin
      ctrl_q <= wdata & DBG_CTRL_WMASK;
    end
  end

  // read data stand for one cycle only, zero otherwise
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_en && sel_id) begin
      rdata_q <= IDENT_VALUE;
    end else if (rd_en && sel_ctrl) begin
      rdata_q <= ctrl_q;
    end else begin
      // unmapped reads and idle cycles give zero
      rdata_q <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // freeze requests while the core is halted
  ////////////////////////////////////////////////////////////////////////

  // timers 4..1 then window, independent watchdog
  logic [DBG_HOLD_N-1:0] hold_q;

  // one registered and-gate per unit
  dbg_hold_gate #(
    .N(DBG_HOLD_N)
  ) u_hold (
    .clk(clk),
    .rstn(rstn),
    .halted(core_halted),
    .sel(ctrl_q[DBG_B_HOLD_HI:DBG_B_HOLD_LO]),
    .hold_q(hold_q)
  );

  // split the flop outputs per unit
  assign tim_hold_q = hold_q[5:2];
  assign win_dog_hold_q = hold_q[1];
  assign ind_dog_hold_q = hold_q[0];

  ////////////////////////////////////////////////////////////////////////
  // low-power clock keeping
  ////////////////////////////////////////////////////////////////////////

  // standby seen last cycle, to find the exit
  logic stby_q;

  // track standby for exit detection
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stby_q <= 1'b0;
    end else begin
      stby_q <= standby_mode;
    end
  end

  // clock keep requests to the clock controller
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sleep_clk_keep_q <= 1'b0;
      fast_clk_keep_q <= 1'b0;
    end else begin
      sleep_clk_keep_q <= sleep_mode & ctrl_q[DBG_B_SLEEP];
      // fast oscillator feeds bus and system clocks
      fast_clk_keep_q <= (deepsleep_mode & ctrl_q[DBG_B_DEEP])
        | (standby_mode & ctrl_q[DBG_B_STBY]);
    end
  end

  // leaving a debug-kept standby forces a system reset;
  // the pulse is one cycle, the reset controller stretches it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      standby_reset_req_q <= 1'b0;
    end else begin
      standby_reset_req_q <= stby_q & !standby_mode
        & ctrl_q[DBG_B_STBY];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin ownership
  ////////////////////////////////////////////////////////////////////////

  // debug owns clock and data pins out of reset; a
  // gpio selection takes them back on the next clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      swclk_pin_dbg_q <= 1'b1;
      swdio_pin_dbg_q <= 1'b1;
      trace_pin_dbg_q <= 1'b0;
    end else begin
      swclk_pin_dbg_q <= !swclk_gpio_sel;
      swdio_pin_dbg_q <= !swdio_gpio_sel;
      // trace needs the enable bit and no gpio claim
      trace_pin_dbg_q <= ctrl_q[DBG_B_TRACE] & !trace_gpio_sel;
    end
  end

  // a session needs swd selected and both pins held;
  // jtag is tracked but cannot carry a session here
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      debug_session_q <= 1'b0;
    end else begin
      debug_session_q <= swd_s & !swclk_gpio_sel
        & !swdio_gpio_sel;
    end
  end

endmodule
`default_nettype wire

//--- verification/dbg_probe.sv
`default_nettype none
// probe model: drives the link clock and the tms/data line
module dbg_probe (
  output logic swclk,
  output logic swdio
);
  timeunit 1ns;
  timeprecision 1ns;
  // clock parked low between frames, data line held by its pull-up
  initial begin
    swclk = 1'b0;
    swdio = 1'b1;
  end
  // one bit per 30 ns clock, data moved while the clock is low
  task automatic bit_out(input logic b);
    swdio = b;
    #15 swclk = 1'b1;
    #15 swclk = 1'b0;
  endtask
  // tail padded past 50 so the synchroniser still gets edges
  task automatic send(input logic [15:0] pat);
    #7;
    for (int i = 0; i < 52; i++) bit_out(1'b1);
    for (int i = 0; i < 16; i++) bit_out(pat[i]);
    for (int i = 0; i < 54; i++) bit_out(1'b1);
  endtask
endmodule
`default_nettype wire

//--- verification/dbg_port_hold_chk.sv
`default_nettype none
module dbg_port_hold_chk
  import dbg_pkg::*;
#(
  parameter logic [31:0] IDENT_VALUE = 32'h1234_5678
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [31:0] addr,
  input wire logic rd_en,
  input wire logic [31:0] rdata_q,
  input wire logic core_halted,
  input wire logic sleep_mode,
  input wire logic deepsleep_mode,
  input wire logic standby_mode,
  input wire logic swclk_gpio_sel,
  input wire logic trace_gpio_sel,
  input wire logic swd_active_q,
  input wire logic jtag_active_q,
  input wire logic [3:0] tim_hold_q,
  input wire logic win_dog_hold_q,
  input wire logic ind_dog_hold_q,
  input wire logic sleep_clk_keep_q,
  input wire logic fast_clk_keep_q,
  input wire logic standby_reset_req_q,
  input wire logic swclk_pin_dbg_q,
  input wire logic trace_pin_dbg_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////
  // read requests by target
  sequence id_rd_s;
    rd_en && addr == DBG_IDENT_ADDR;
  endsequence
  sequence ctrl_rd_s;
    rd_en && addr == DBG_CTRL_ADDR;
  endsequence
  // standby exit: mode fell one cycle back, pulse over next cycle;
  // a quick re-entry into standby must not count against the pulse
  sequence stby_gone_s;
    $past(standby_mode, 2) && !$past(standby_mode) ##1 !standby_reset_req_q;
  endsequence
  ////////////////////
  proto_onehot_a: assert property (swd_active_q != jtag_active_q)
    else $error("protocol select not one-hot");
  read_idle_a: assert property (!$past(rd_en) |-> rdata_q == 32'h0000_0000)
    else $error("read data outside read slot");
  ident_read_a: assert property (id_rd_s |=> rdata_q == IDENT_VALUE)
    else $error("identity word wrong");
  ctrl_resv_a: assert property (ctrl_rd_s |=> (rdata_q & ~DBG_CTRL_WMASK) == 0)
    else $error("reserved control bits set");
  timer_hold_a: assert property (|tim_hold_q |-> $past(core_halted))
    else $error("timer hold without halt");
  dog_hold_a: assert property (win_dog_hold_q || ind_dog_hold_q |->
    $past(core_halted))
    else $error("watchdog hold without halt");
  hold_free_a: assert property ($fell(core_halted) |=>
    !(|tim_hold_q || win_dog_hold_q || ind_dog_hold_q))
    else $error("hold not released");
  sleep_keep_a: assert property (sleep_clk_keep_q |-> $past(sleep_mode))
    else $error("sleep keep without sleep");
  fast_keep_a: assert property (fast_clk_keep_q |->
    $past(deepsleep_mode || standby_mode))
    else $error("fast clock keep without low power");
  stby_pulse_a: assert property (standby_reset_req_q |-> stby_gone_s)
    else $error("standby reset pulse wrong");
  pin_free_a: assert property (swclk_gpio_sel |=> !swclk_pin_dbg_q)
    else $error("clock pin not released");
  trace_pin_a: assert property (trace_pin_dbg_q |-> !$past(trace_gpio_sel))
    else $error("trace pin kept by debug");
endmodule
bind dbg_port_hold dbg_port_hold_chk #(.IDENT_VALUE(IDENT_VALUE)) dbg_port_hold_chk_i (
  .clk, .rstn, .addr, .rd_en, .rdata_q, .core_halted, .sleep_mode, .deepsleep_mode,
  .standby_mode, .swclk_gpio_sel, .trace_gpio_sel, .swd_active_q, .jtag_active_q,
  .tim_hold_q, .win_dog_hold_q, .ind_dog_hold_q, .sleep_clk_keep_q, .fast_clk_keep_q,
  .standby_reset_req_q, .swclk_pin_dbg_q, .trace_pin_dbg_q);
`default_nettype wire

//--- verification/tb.sv
`default_nettype none
module tb
  import dbg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] IDV = 32'h1234_5678; // arbitrary identity value
  // reset starts high so that its fall at time zero resets the link-clock flops too
  logic clk = 0, rstn = 1, wr_en = 0, rd_en = 0;
  logic [31:0] addr = 0, wdata = 0, rdata_q, v, m;
  logic core_halted = 0, sleep_mode = 0, deepsleep_mode = 0, standby_mode = 0;
  logic swclk_gpio_sel = 0, swdio_gpio_sel = 0, trace_gpio_sel = 0;
  logic swclk, probe_dio, swdio_out_q, swdio_oe_n_q, swd_active_q, jtag_active_q;
  logic debug_session_q, win_dog_hold_q, ind_dog_hold_q, sleep_clk_keep_q, fast_clk_keep_q;
  logic standby_reset_req_q, swclk_pin_dbg_q, swdio_pin_dbg_q, trace_pin_dbg_q;
  logic [3:0] tim_hold_q;
  logic [4:0] st;
  logic [2:0] n;
  wire logic swdio_in;
  int n_errors = 0, check_count = 0;
  // wire level: design end only ever listens, probe drives otherwise
  assign swdio_in = swdio_oe_n_q ? probe_dio : swdio_out_q;
  always #50 clk = ~clk;
  dbg_port_hold #(.IDENT_VALUE(IDV)) dbg_port_hold_i (.clk, .rstn, .addr, .wdata, .wr_en,
    .rd_en, .rdata_q, .core_halted, .sleep_mode, .deepsleep_mode, .standby_mode,
    .swclk_gpio_sel, .swdio_gpio_sel, .trace_gpio_sel, .swclk, .swdio_in, .swdio_out_q,
    .swdio_oe_n_q, .swd_active_q, .jtag_active_q, .debug_session_q, .tim_hold_q,
    .win_dog_hold_q, .ind_dog_hold_q, .sleep_clk_keep_q, .fast_clk_keep_q, .standby_reset_req_q,
    .swclk_pin_dbg_q, .swdio_pin_dbg_q, .trace_pin_dbg_q);
  dbg_probe dbg_probe_i (.swclk(swclk), .swdio(probe_dio));
  ////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one-cycle strobes, released on the next edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    {wr_en, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk);
    {rd_en, addr} <= {1'b1, a};
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    chk("rdata", e, rdata_q);
  endtask
  // link switch, then a bounded wait for the protocol flags
  // a wait that runs out is a mismatch and ends the run
  task automatic link(input logic [15:0] p, input logic [1:0] e);
    int i;
    dbg_probe_i.send(p);
    i = 0;
    while (i < 20 && {swd_active_q, jtag_active_q} !== e) begin
      @(posedge clk);
      i++;
    end
    if (i == 20) begin
      n_errors++;
      $display("Error link expected %h seen %h", e, {swd_active_q, jtag_active_q});
      give_verdict();
    end
    @(negedge clk);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  ////////////////////
  initial begin
    rstn <= 1'b0;
    void'($urandom(3224));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk("jtag", 2'b01, {swd_active_q, jtag_active_q});
    chk("pins", 3'b110, {swclk_pin_dbg_q, swdio_pin_dbg_q, trace_pin_dbg_q});
    rd(DBG_CTRL_ADDR, 0);
    wr(DBG_IDENT_ADDR, ~IDV);
    rd(DBG_IDENT_ADDR, IDV);
    rd(DBG_IDENT_ADDR + 32'h0000_0008, 0);
    // model: control word kept as written under the writable mask
    for (int k = 0; k < 8; k++) begin
      v = (k == 0) ? 32'hFFFF_FFFF : $urandom;
      st = (k == 0) ? 5'h1E : 5'($urandom);
      m = v & DBG_CTRL_WMASK;
      wr(DBG_CTRL_ADDR, v);
      rd(DBG_CTRL_ADDR, m);
      @(posedge clk);
      {core_halted, sleep_mode, deepsleep_mode, standby_mode, trace_gpio_sel} <= st;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("hold", st[4] ? m[13:8] : 0, {tim_hold_q, win_dog_hold_q, ind_dog_hold_q});
      chk("keep", {st[3] & m[0], st[2] & m[1] | st[1] & m[2]},
        {sleep_clk_keep_q, fast_clk_keep_q});
      chk("trace", m[5] & !st[0], trace_pin_dbg_q);
      @(posedge clk);
      {core_halted, sleep_mode, deepsleep_mode, standby_mode} <= 4'h0;
      n = 0;
      repeat (4) begin
        @(posedge clk);
        #1 n = n + standby_reset_req_q;
      end
      chk("stby_rst", st[1] & m[2], n);
      chk("free", 0, {tim_hold_q, win_dog_hold_q, ind_dog_hold_q});
    end
    link(DBG_SEQ_TO_SWD, 2'b10);
    chk("to_swd", 2'b10, {swd_active_q, jtag_active_q});
    chk("session", 1, debug_session_q);
    // this unit only listens on the data line
    chk("dio", 2'b10, {swdio_oe_n_q, swdio_out_q});
    // a corrupted exit word must leave serial wire selected
    link(DBG_SEQ_TO_JTAG ^ 16'h0100, 2'b10);
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("bad_seq", 2'b10, {swd_active_q, jtag_active_q});
    @(posedge clk);
    {swclk_gpio_sel, swdio_gpio_sel} <= 2'b11;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("gpio", 3'b000, {swclk_pin_dbg_q, swdio_pin_dbg_q, debug_session_q});
    @(posedge clk);
    {swclk_gpio_sel, swdio_gpio_sel} <= 2'b00;
    link(DBG_SEQ_TO_JTAG, 2'b01);
    chk("to_jtag", 2'b01, {swd_active_q, jtag_active_q});
    wr(DBG_CTRL_ADDR, 32'h0000_3F27);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk("jtag_again", 2'b01, {swd_active_q, jtag_active_q});
    rd(DBG_CTRL_ADDR, 0);
    give_verdict();
  end
endmodule
`default_nettype wire
